// ==== hdl/tla_pkg.sv ====
// package: constants and carrier types for the trip-point register block
package tla_pkg;

  // register pointers
  localparam logic [7:0] TLA_PTR_UPPER = 8'h02;
  localparam logic [7:0] TLA_PTR_LOWER = 8'h03;
  localparam logic [7:0] TLA_PTR_CRIT  = 8'h04;

  // field layout of a trip-point register
  localparam int TLA_SIGN_BIT = 12;
  localparam int TLA_MAG_HI   = 11;
  localparam int TLA_MAG_LO   = 2;
  // writable bits: 12 down to 2, reserved bits 15:13 and 1:0 held at zero
  localparam logic [15:0] TLA_TRIP_MASK  = 16'h1FFC;
  localparam logic [15:0] TLA_TRIP_RESET = 16'h0000;
  localparam logic [15:0] TLA_READ_NONE  = 16'h0000;

  // measured temperature field, eighth-degree units, bits 12:1
  localparam int TLA_TEMP_HI = 12;
  localparam int TLA_TEMP_LO = 1;

  // hysteresis in eighth-degree steps: 0, 1.5, 3.0, 6.0 degrees
  localparam logic signed [13:0] TLA_HYST_0   = 14'sh0000;
  localparam logic signed [13:0] TLA_HYST_1P5 = 14'sh000C;
  localparam logic signed [13:0] TLA_HYST_3P0 = 14'sh0018;
  localparam logic signed [13:0] TLA_HYST_6P0 = 14'sh0030;

  // hysteresis codes
  typedef enum logic [1:0] {
    TLA_HYS_OFF = 2'b00,
    TLA_HYS_1P5 = 2'b01,
    TLA_HYS_3P0 = 2'b10,
    TLA_HYS_6P0 = 2'b11
  } tla_hys_t;

  // one register access from the serial bus engine
  typedef struct packed {
    logic        wr;    // write strobe, one cycle
    logic        rd;    // read strobe, one cycle
    logic [7:0]  ptr;   // register pointer
    logic [15:0] wdata; // write data
  } tla_req_t;

  // comparator status shown to the rest of the unit
  typedef struct packed {
    logic crit;  // above critical, held through hysteresis
    logic upper; // above upper, held through hysteresis
    logic lower; // below lower minus hysteresis, until back to lower
  } tla_stat_t;

endpackage

// ==== hdl/tla_trip_regs.sv ====
// module: trip-point registers, lock bits and window comparators
`timescale 1ns/100ps
`default_nettype none

module tla_trip_regs (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  input  wire tla_pkg::tla_req_t req,
  output logic [15:0]            rd_data_q,
  input  wire logic [15:0]       temp_meas,
  input  wire logic [1:0]        hysteresis_select,
  input  wire logic              alert_output_enable,
  input  wire logic              window_lock_set,
  input  wire logic              critical_lock_set,
  output logic                   window_lock_bit,
  output logic                   critical_lock_bit,
  output tla_pkg::tla_stat_t     stat_q,
  output logic                   alert_q
);

  // threshold field widened to eighth-degree units, fine bit zero
  function automatic logic signed [13:0] trip_eighths(
    input logic [15:0] r
  );
    logic [11:0] f;
    f = {r[tla_pkg::TLA_SIGN_BIT:tla_pkg::TLA_MAG_LO], 1'b0};
    // bit 12 is the sign, so it is copied upward
    trip_eighths = signed'({{2{f[11]}}, f});
  endfunction

  // limit lowered by the hysteresis step, the falling-side point
  function automatic logic signed [13:0] less_hyst(
    input logic signed [13:0] lim,
    input logic signed [13:0] hys
  );
    // both stay inside +-512 degrees, so 14 bits cannot wrap
    less_hyst = lim - hys;
  endfunction

  // storage and the aligned views the comparators work on
  logic [15:0]        upper_q;   // upper trip point
  logic [15:0]        lower_q;   // lower trip point
  logic [15:0]        crit_q;    // critical trip point
  logic               win_lock_q;  // window lock, sticky
  logic               crit_lock_q; // critical lock, sticky
  logic signed [13:0] temp_s;    // measured temperature, eighths
  logic signed [13:0] hyst_s;    // selected hysteresis, eighths
  logic signed [13:0] up_s;      // upper limit, eighths
  logic signed [13:0] lo_s;      // lower limit, eighths
  logic signed [13:0] cr_s;      // critical limit, eighths
  logic signed [13:0] up_clr_s;  // upper clear point, eighths
  logic signed [13:0] lo_set_s;  // lower set point, eighths
  logic signed [13:0] cr_clr_s;  // critical clear point, eighths
  logic [15:0]        wmask;     // write data with reserved bits cleared
  logic [15:0]        rd_d;      // read mux result

  // temperature arrives from the sensor core on this clock, so no sync
  // bit 12 is the sign and is copied into the two top bits
  assign temp_s = signed'({{2{temp_meas[tla_pkg::TLA_TEMP_HI]}},
                   temp_meas[tla_pkg::TLA_TEMP_HI:tla_pkg::TLA_TEMP_LO]});
  assign up_s   = trip_eighths(upper_q);
  assign lo_s   = trip_eighths(lower_q);
  assign cr_s   = trip_eighths(crit_q);
  // falling-side points; the rising side uses the bare limits
  assign up_clr_s = less_hyst(up_s, hyst_s);
  assign lo_set_s = less_hyst(lo_s, hyst_s);
  assign cr_clr_s = less_hyst(cr_s, hyst_s);
  // reserved bits never reach storage, so reads show zero
  assign wmask  = req.wdata & tla_pkg::TLA_TRIP_MASK;

  // hysteresis code to a step count
  always_comb
  begin
    case (tla_pkg::tla_hys_t'(hysteresis_select))
      tla_pkg::TLA_HYS_1P5: hyst_s = tla_pkg::TLA_HYST_1P5;
      tla_pkg::TLA_HYS_3P0: hyst_s = tla_pkg::TLA_HYST_3P0;
      tla_pkg::TLA_HYS_6P0: hyst_s = tla_pkg::TLA_HYST_6P0;
      // the off code lands here as well
      default:              hyst_s = tla_pkg::TLA_HYST_0;
    endcase
  end

  // lock bits: set by the configuration logic, cleared only by reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // power-on reset is the only way a lock ever falls
      win_lock_q  <= 1'b0;
      crit_lock_q <= 1'b0;
    end
    else if (clk_en)
    begin
      // no path here ever clears a lock once set
      if (window_lock_set)
        win_lock_q <= 1'b1;
      if (critical_lock_set)
        crit_lock_q <= 1'b1;
    end
  end

  assign window_lock_bit   = win_lock_q;
  assign critical_lock_bit = crit_lock_q;

  // trip-point writes, each refused while its lock stands
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // zero limits: with zero temperature nothing trips
      upper_q <= tla_pkg::TLA_TRIP_RESET;
      lower_q <= tla_pkg::TLA_TRIP_RESET;
      crit_q  <= tla_pkg::TLA_TRIP_RESET;
    end
    else if (clk_en && req.wr)
    begin
      // a lock set in the same cycle does not yet stop the write
      // pointers outside the three trip words fall through, dropped
      if (req.ptr == tla_pkg::TLA_PTR_UPPER)
      begin
        if (!win_lock_q)
          upper_q <= wmask;
      end
      else if (req.ptr == tla_pkg::TLA_PTR_LOWER)
      begin
        if (!win_lock_q)
          lower_q <= wmask;
      end
      else if (req.ptr == tla_pkg::TLA_PTR_CRIT)
      begin
        // only the critical lock guards this one
        if (!crit_lock_q)
          crit_q <= wmask;
      end
    end
  end

  // read mux, unmapped pointers read as zero
  always_comb
  begin
    if (req.ptr == tla_pkg::TLA_PTR_UPPER)
      rd_d = upper_q;
    else if (req.ptr == tla_pkg::TLA_PTR_LOWER)
      rd_d = lower_q;
    else if (req.ptr == tla_pkg::TLA_PTR_CRIT)
      rd_d = crit_q;
    else
      // configuration, result and identity words live elsewhere
      rd_d = tla_pkg::TLA_READ_NONE;
  end

  // read data is captured on the read strobe and held
  // holding lets a slow bus engine shift the word out at leisure
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data_q <= tla_pkg::TLA_READ_NONE;
    else if (clk_en && req.rd)
      rd_data_q <= rd_d;
  end

  // window comparators with hysteresis on the falling side only
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      stat_q <= '0;
    else if (clk_en)
    begin
      // all three compare signed, in eighth-degree units
      // upper: set above limit, clear at or below limit minus hysteresis
      if (temp_s > up_s)
        stat_q.upper <= 1'b1;
      else if (temp_s <= up_clr_s)
        stat_q.upper <= 1'b0;
      // between the two points the flag keeps its value
      // lower: set below limit minus hysteresis, clear at limit
      if (temp_s < lo_set_s)
        stat_q.lower <= 1'b1;
      else if (temp_s >= lo_s)
        stat_q.lower <= 1'b0;
      // critical: same shape as upper
      if (temp_s > cr_s)
        stat_q.crit <= 1'b1;
      else if (temp_s <= cr_clr_s)
        stat_q.crit <= 1'b0;
    end
  end

  // event output follows the held conditions while enabled
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      alert_q <= 1'b0;
    else if (clk_en)
      // masking here leaves stat_q running while the output is off
      alert_q <= alert_output_enable &
                 (stat_q.upper | stat_q.lower |
                  stat_q.crit);
  end

endmodule

`default_nettype wire

// ==== testbench/tla_host_model.sv ====
// host-side model: issues register strobes to the trip block
`timescale 1ns/100ps
`default_nettype none
module tla_host_model (
  input  wire logic             clk,
  input  wire logic [15:0]      rdata,
  output var tla_pkg::tla_req_t req
);
  initial req = '0;
  // one-cycle write strobe, launched off the falling edge
  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    @(negedge clk);
    req <= '{1'b1, 1'b0, p, v};
    @(negedge clk);
    req <= '0;
  endtask
  // read strobe; data is registered before the next falling edge
  task automatic rd(input logic [7:0] p, output logic [15:0] v);
    @(negedge clk);
    req <= '{1'b0, 1'b1, p, 16'h0000};
    @(negedge clk);
    req <= '0;
    v = rdata;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tla_trip_regs_assertions.sv ====
// checker for the trip-point register block ports
`timescale 1ns/100ps
`default_nettype none
module tla_trip_regs_assertions (
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic               clk_en,
  input wire tla_pkg::tla_req_t  req,
  input wire logic [15:0]        rd_data_q,
  input wire logic               alert_output_enable,
  input wire logic               window_lock_set,
  input wire logic               critical_lock_set,
  input wire logic               window_lock_bit,
  input wire logic               critical_lock_bit,
  input wire tla_pkg::tla_stat_t stat_q,
  input wire logic               alert_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RSV: assert property (
    (rd_data_q & 16'hE003) == 16'h0000) else $error("reserved bit read");
  AST_UNMAP: assert property (
    clk_en && req.rd && !(req.ptr inside {[8'h02:8'h04]})
    |=> rd_data_q == 16'h0000) else $error("unmapped read not zero");
  AST_HOLD: assert property (
    !(clk_en && req.rd) |=> $stable(rd_data_q)) else $error("read moved");
  AST_ALERT: assert property (
    clk_en |=> alert_q == $past(alert_output_enable && (|stat_q)))
    else $error("event output wrong");
  AST_WSET: assert property (
    clk_en && window_lock_set |=> window_lock_bit) else $error("no lock");
  AST_CSET: assert property (
    clk_en && critical_lock_set |=> critical_lock_bit) else $error("no lock");
  AST_WKEEP: assert property (
    window_lock_bit |=> window_lock_bit) else $error("window lock lost");
  AST_CKEEP: assert property (
    critical_lock_bit |=> critical_lock_bit) else $error("crit lock lost");
  COV_ALERT: cover property ($rose(alert_q));
  COV_LOW: cover property (stat_q.lower);
  COV_CLOCK: cover property ($rose(critical_lock_bit));
endmodule
bind tla_trip_regs tla_trip_regs_assertions tla_trip_regs_assertions_i (.*);
`default_nettype wire

// ==== testbench/tla_trip_regs_tb.sv ====
// self-checking bench for the trip-point register block
`timescale 1ns/100ps
`default_nettype none
module tla_trip_regs_tb;
  logic clk, rst_b, ce, en, wls, cls, wlb, clb, alert;
  logic [15:0] temp, rdat, d;
  logic [1:0] hys;
  tla_pkg::tla_stat_t stat;
  tla_pkg::tla_req_t req;
  int errors = 0;
  int check_count = 0;
  tla_trip_regs tla_trip_regs_i (.clk(clk), .rst_b(rst_b), .clk_en(ce),
    .req(req), .rd_data_q(rdat), .temp_meas(temp), .hysteresis_select(hys),
    .alert_output_enable(en), .window_lock_set(wls),
    .critical_lock_set(cls), .window_lock_bit(wlb),
    .critical_lock_bit(clb), .stat_q(stat), .alert_q(alert));
  tla_host_model tla_host_model_i (.clk(clk), .rdata(rdat), .req(req));
  task automatic summarize;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic w(input logic [7:0] p, input logic [15:0] v);
    tla_host_model_i.wr(p, v);
  endtask
  task automatic r(input logic [7:0] p, input logic [15:0] e);
    tla_host_model_i.rd(p, d);
    cmp(d, e);
  endtask
  // new temperature; status lands one cycle on, event one after that
  task automatic t(input logic [15:0] v, input logic [3:0] e);
    temp = v;
    repeat (2) @(negedge clk);
    cmp({12'h000, alert, stat}, {12'h000, e});
  endtask
  // reset values, then reserved bits dropped on write
  task automatic test_reset_values;
    for (int p = 2; p < 5; p++)
    begin
      r(8'(p), 16'h0000);
      w(8'(p), 16'hFFFF);
      r(8'(p), 16'h1FFC);
    end
    r(8'h05, 16'h0000);
  endtask
  // upper 85C, lower -16C, critical 200C, 1.5C hysteresis
  task automatic test_upper;
    w(8'h04, 16'h0C80);
    w(8'h03, 16'h1F00);
    w(8'h02, 16'h0550);
    r(8'h02, 16'h0550);
    r(8'h03, 16'h1F00);
    hys = 2'b01;
    en = 1'b1;
    t(16'h0552, 4'b1010);
    t(16'h053A, 4'b1010);
    t(16'h0538, 4'b0000);
  endtask
  // lower 20C with 3C hysteresis
  task automatic test_lower;
    w(8'h03, 16'h0140);
    hys = 2'b10;
    t(16'h0110, 4'b0000);
    t(16'h010E, 4'b1001);
    t(16'h013E, 4'b1001);
    t(16'h0140, 4'b0000);
  endtask
  // upper to 200C, critical 80C, 6C hysteresis, event masked midway
  task automatic test_critical;
    w(8'h02, 16'h0C80);
    w(8'h04, 16'h0500);
    hys = 2'b11;
    t(16'h0502, 4'b1100);
    en = 1'b0;
    t(16'h04A2, 4'b0100);
    t(16'h04A0, 4'b0000);
  endtask
  // clock enable low freezes storage and comparators
  task automatic test_freeze;
    ce = 1'b0;
    w(8'h02, 16'h0100);
    t(16'h0600, 4'b0000);
    ce = 1'b1;
    r(8'h02, 16'h0C80);
    t(16'h0600, 4'b0100);
    t(16'h04A0, 4'b0000);
  endtask
  // window lock blocks upper/lower only, critical lock the third
  task automatic test_locks;
    wls = 1'b1;
    w(8'h02, 16'h0124);
    w(8'h03, 16'h0124);
    w(8'h04, 16'h0124);
    r(8'h02, 16'h0C80);
    r(8'h03, 16'h0140);
    r(8'h04, 16'h0124);
    {wls, cls} = 2'b01;
    w(8'h04, 16'h0000);
    r(8'h04, 16'h0124);
    cls = 1'b0;
    cmp({14'h0000, wlb, clb}, 16'h0003);
  endtask
  // second power-on reset clears both locks and the critical limit
  task automatic test_power_on_reset;
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    cmp({14'h0000, wlb, clb}, 16'h0000);
    r(8'h04, 16'h0000);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog: the whole run needs well under 2000 cycles
  initial
  begin
    #50000;
    errors++;
    summarize;
  end
  initial
  begin
    {rst_b, en, wls, cls, hys, temp} = '0;
    ce = 1'b1;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    test_reset_values;
    test_upper;
    test_lower;
    test_critical;
    test_freeze;
    test_locks;
    test_power_on_reset;
    summarize;
  end
endmodule
`default_nettype wire
